// ==== phymr_register_view.sv ====
// Purpose: Port-1 status/ident/advertise/partner and port-2 control regs
// Assumes: 16-bit host bus, byte addresses, even address per register
// Notes:   Read data registered, valid one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none

`include "phymr_defines.svh"

module phymr_register_view
    import phymr_pkg::*;
#(
    // Identifier words; values are arbitrary
    parameter phymr_word_t ID_LOW  = 16'h5A01,
    parameter phymr_word_t ID_HIGH = 16'h00A5
)
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // Host register bus
    input  wire phymr_addr_t host_addr,
    input  wire logic        host_wr,
    input  wire logic        host_rd,
    input  wire logic [1:0]  host_be,
    input  wire phymr_word_t host_wdata,
    output phymr_word_t      host_rdata,
    output logic             host_rvalid,
    // Port-1 PHY side
    input  wire phymr_word_t port1_status_mirror,
    output phymr_word_t      port1_control_mirror,
    output phymr_word_t      port1_adv_word,
    // Port-2 PHY side
    input  wire logic        port2_an_failed,
    output phymr_word_t      port2_control_mirror,
    output logic             port2_loopback,
    output logic             port2_an_enable,
    output logic             port2_an_restart,
    output logic             port2_speed_forced,
    output logic             port2_speed_100,
    output logic             port2_duplex_forced,
    output logic             port2_duplex_full
);

    // Address match on either byte of a 16-bit register, bit 0 ignored
    function automatic logic hit(input phymr_addr_t a, input phymr_addr_t o);
        hit = (a[7:1] == o[7:1]);
    endfunction : hit

    // Merge write data under byte enables
    function automatic phymr_word_t merge(input phymr_word_t old,
                                          input phymr_word_t wd,
                                          input logic [1:0]  be);
        merge = old;
        if (be[0])
            merge[7:0] = wd[7:0];
        if (be[1])
            merge[15:8] = wd[15:8];
    endfunction : merge

    // Sampled port-1 status
    logic       an_done_q;
    logic       an_done_d;
    logic       link_q;
    logic       link_d;
    logic       lp_pause_q;
    logic       lp_pause_d;
    logic [3:0] lp_ab_q;
    logic [3:0] lp_ab_d;

    // Advertisement state
    logic       adv_pause_q;
    logic       adv_pause_d;
    logic       adv_rsv9_q;
    logic       adv_rsv9_d;
    logic [3:0] adv_ab_q;
    logic [3:0] adv_ab_d;

    // Port-2 control state
    logic       lb_q;
    logic       lb_d;
    logic       f100_q;
    logic       f100_d;
    logic       an_en_q;
    logic       an_en_d;
    logic       dup_q;
    logic       dup_d;
    logic       rst_start;
    logic       rst_bit;
    logic       rst_pulse;

    // Read path
    phymr_word_t rdata_q;
    phymr_word_t rdata_d;
    logic        rvalid_q;
    logic        rvalid_d;

    // Register images
    phymr_word_t sts_word;
    phymr_word_t adv_word;
    phymr_word_t lp_word;
    phymr_word_t ctl_word;
    phymr_word_t wr_adv;
    phymr_word_t wr_ctl;

    // Status sampling
    // [RL2] Mirror negotiation and link
    always_comb
    begin
        an_done_d  = port1_status_mirror[`PHYMR_SR_AN_DONE];
        link_d     = port1_status_mirror[`PHYMR_SR_LINK];
        // [RL12] Partner pause mirror
        lp_pause_d = port1_status_mirror[`PHYMR_SR_LP_PAUSE];
        // [RL13] Partner ability mirror
        lp_ab_d    = port1_status_mirror[`PHYMR_SR_LP_MSB:0];
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            an_done_q  <= 1'b0;
            link_q     <= 1'b0;
            lp_pause_q <= 1'b0;
            lp_ab_q    <= `PHYMR_LP_RST;
        end
        else
        begin
            an_done_q  <= an_done_d;
            link_q     <= link_d;
            lp_pause_q <= lp_pause_d;
            lp_ab_q    <= lp_ab_d;
        end
    end

    // Images of the readable registers
    always_comb
    begin
        sts_word = '0;
        // [RL1] Fixed capability flags
        sts_word[`PHYMR_STS_CAP_MSB:`PHYMR_STS_CAP_LSB] = `PHYMR_STS_CAP_VAL;
        sts_word[`PHYMR_STS_AN_DONE] = an_done_q;
        // [RL3] Always negotiation capable
        sts_word[`PHYMR_STS_AN_ABLE] = 1'b1;
        sts_word[`PHYMR_STS_LINK]    = link_q;
        // [RL4] Reserved and extended stay zero

        // [RL9] Next page left zero
        adv_word = '0;
        adv_word[`PHYMR_ADV_PAUSE] = adv_pause_q;
        adv_word[`PHYMR_ADV_RSV9]  = adv_rsv9_q;
        adv_word[`PHYMR_ADV_AB_MSB:`PHYMR_ADV_AB_LSB] = adv_ab_q;
        adv_word[`PHYMR_ADV_SEL_MSB:0] = `PHYMR_ADV_SEL_VAL;

        // [RL10] [RL11] Fault and acknowledge zero
        lp_word = '0;
        lp_word[`PHYMR_ADV_PAUSE] = lp_pause_q;
        lp_word[`PHYMR_ADV_AB_MSB:`PHYMR_ADV_AB_LSB] = lp_ab_q;
        lp_word[`PHYMR_ADV_SEL_MSB:0] = `PHYMR_ADV_SEL_VAL;

        ctl_word = '0;
        ctl_word[`PHYMR_CTL_LOOPBACK] = lb_q;
        ctl_word[`PHYMR_CTL_FORCE100] = f100_q;
        ctl_word[`PHYMR_CTL_AN_EN]    = an_en_q;
        ctl_word[`PHYMR_CTL_RESTART]  = rst_bit;
        ctl_word[`PHYMR_CTL_DUPLEX]   = dup_q;
    end

    // Write data merged onto current images
    assign wr_adv = merge(adv_word, host_wdata, host_be);
    assign wr_ctl = merge(ctl_word, host_wdata, host_be);

    // Advertisement register
    // [RL19] Only writable fields are taken
    always_comb
    begin
        adv_pause_d = adv_pause_q;
        adv_rsv9_d  = adv_rsv9_q;
        adv_ab_d    = adv_ab_q;
        if (host_wr && hit(host_addr, `PHYMR_OFS_P1_ADV))
        begin
            // [RL7] Pause advertisement write
            adv_pause_d = wr_adv[`PHYMR_ADV_PAUSE];
            adv_rsv9_d  = wr_adv[`PHYMR_ADV_RSV9];
            // [RL8] Ability advertisement write
            adv_ab_d    = wr_adv[`PHYMR_ADV_AB_MSB:`PHYMR_ADV_AB_LSB];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            adv_pause_q <= `PHYMR_ADV_PAUSE_RST;
            adv_rsv9_q  <= 1'b0;
            adv_ab_q    <= `PHYMR_ADV_AB_RST;
        end
        else
        begin
            adv_pause_q <= adv_pause_d;
            adv_rsv9_q  <= adv_rsv9_d;
            adv_ab_q    <= adv_ab_d;
        end
    end

    // Port-2 control register
    always_comb
    begin
        lb_d      = lb_q;
        f100_d    = f100_q;
        an_en_d   = an_en_q;
        dup_d     = dup_q;
        rst_start = 1'b0;
        if (host_wr && hit(host_addr, `PHYMR_OFS_P2_CONTROL))
        begin
            // [RL14] Loopback enable write
            lb_d    = wr_ctl[`PHYMR_CTL_LOOPBACK];
            // [RL15] Forced speed write
            f100_d  = wr_ctl[`PHYMR_CTL_FORCE100];
            // [RL16] Negotiation enable write
            an_en_d = wr_ctl[`PHYMR_CTL_AN_EN];
            // [RL18] Forced duplex write
            dup_d   = wr_ctl[`PHYMR_CTL_DUPLEX];
            // [RL17] Restart on written one
            rst_start = host_be[1] && host_wdata[`PHYMR_CTL_RESTART];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            lb_q    <= `PHYMR_CTL_LB_RST;
            f100_q  <= `PHYMR_CTL_F100_RST;
            an_en_q <= `PHYMR_CTL_AN_RST;
            dup_q   <= `PHYMR_CTL_DUP_RST;
        end
        else
        begin
            lb_q    <= lb_d;
            f100_q  <= f100_d;
            an_en_q <= an_en_d;
            dup_q   <= dup_d;
        end
    end

    phymr_restart_ctl u_restart (
        .ref_clk       (ref_clk),
        .sys_rst       (sys_rst),
        .start         (rst_start),
        .restart_bit   (rst_bit),
        .restart_pulse (rst_pulse)
    );

    // Read path, unmapped addresses return zero
    always_comb
    begin
        rdata_d  = rdata_q;
        rvalid_d = host_rd;
        if (host_rd)
        begin
            if (hit(host_addr, `PHYMR_OFS_P1_STATUS))
                rdata_d = sts_word;
            // [RL5] Fixed low identifier
            else if (hit(host_addr, `PHYMR_OFS_P1_ID_LOW))
                rdata_d = ID_LOW;
            // [RL6] Fixed high identifier
            else if (hit(host_addr, `PHYMR_OFS_P1_ID_HIGH))
                rdata_d = ID_HIGH;
            else if (hit(host_addr, `PHYMR_OFS_P1_ADV))
                rdata_d = adv_word;
            else if (hit(host_addr, `PHYMR_OFS_P1_PARTNER))
                rdata_d = lp_word;
            else if (hit(host_addr, `PHYMR_OFS_P2_CONTROL))
                rdata_d = ctl_word;
            else
                rdata_d = '0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            rdata_q  <= '0;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign host_rdata  = rdata_q;
    assign host_rvalid = rvalid_q;

    // Mirrors toward the port logic
    always_comb
    begin
        port1_control_mirror = '0;
        port1_control_mirror[`PHYMR_CR4_PAUSE]  = adv_pause_q;
        port1_control_mirror[`PHYMR_ADV_AB_LSB-2:0] = adv_ab_q;
        port2_control_mirror = '0;
        port2_control_mirror[`PHYMR_CR4_LOOPBACK] = lb_q;
        port2_control_mirror[`PHYMR_CR4_AN_EN]    = an_en_q;
        port2_control_mirror[`PHYMR_CR4_FORCE100] = f100_q;
        port2_control_mirror[`PHYMR_CR4_DUPLEX]   = dup_q;
        port2_control_mirror[`PHYMR_CR4_RESTART]  = rst_bit;
    end

    // [RL7] [RL8] Advertised code word
    assign port1_adv_word = adv_word;

    // [RL14] Loopback toward port-2 media layer
    assign port2_loopback     = lb_q;
    // [RL16] Negotiation enable
    assign port2_an_enable    = an_en_q;
    assign port2_an_restart   = rst_pulse;
    // [RL15] Forced speed only without negotiation
    assign port2_speed_forced = !an_en_q;
    assign port2_speed_100    = f100_q;
    // [RL18] Forced duplex when off or failed
    assign port2_duplex_forced = !an_en_q || port2_an_failed;
    assign port2_duplex_full   = dup_q;

endmodule : phymr_register_view

`default_nettype wire

// ==== phymr_defines.svh ====
// Purpose: Offsets, field positions, reset values for the PHY register view
// Assumes: 16-bit registers at even byte addresses on the host bus
// Notes:   Included by the register view only
//
// Summary of operation
// [RL1] Status reports fixed speed and duplex capabilities
// [RL2] Status shows negotiation done and link up
// [RL3] Status bit 3 always reads one
// [RL4] No extended registers; bits 10-7 read zero
// [RL5] Low identifier word is fixed, read-only
// [RL6] High identifier word is fixed, read-only
// [RL7] Writable pause advertisement, default one
// [RL8] Writable speed and duplex advertisement, default one
// [RL9] Next page reads zero in both words
// [RL10] Partner remote fault reads zero
// [RL11] Partner acknowledge reads zero
// [RL12] Partner pause is read-only status mirror
// [RL13] Partner abilities read-only, reset zero
// [RL14] Port-2 far-end loopback enable, default zero
// [RL15] Forced speed bit, one means 100
// [RL16] Negotiation enable bit, default one
// [RL17] Writing restart bit restarts, then self-clears
// [RL18] Duplex bit applies when negotiation off/failed
// [RL19] Read-only and reserved writes are ignored; advertisement reserved bit 9 is stored
`ifndef PHYMR_DEFINES_SVH
`define PHYMR_DEFINES_SVH

// Byte offsets of the registers
`define PHYMR_OFS_P1_STATUS   8'h4E
`define PHYMR_OFS_P1_ID_LOW   8'h50
`define PHYMR_OFS_P1_ID_HIGH  8'h52
`define PHYMR_OFS_P1_ADV      8'h54
`define PHYMR_OFS_P1_PARTNER  8'h56
`define PHYMR_OFS_P2_CONTROL  8'h58

// Basic status fields
`define PHYMR_STS_CAP_MSB     15
`define PHYMR_STS_CAP_LSB     11
`define PHYMR_STS_CAP_VAL     5'h0F
`define PHYMR_STS_AN_DONE     5
`define PHYMR_STS_AN_ABLE     3
`define PHYMR_STS_LINK        2

// Per-port status mirror fields
`define PHYMR_SR_AN_DONE      6
`define PHYMR_SR_LINK         5
`define PHYMR_SR_LP_PAUSE     4
`define PHYMR_SR_LP_MSB       3

// Advertisement and partner fields
`define PHYMR_ADV_PAUSE       10
`define PHYMR_ADV_RSV9        9
`define PHYMR_ADV_AB_MSB      8
`define PHYMR_ADV_AB_LSB      5
`define PHYMR_ADV_SEL_MSB     4
`define PHYMR_ADV_SEL_VAL     5'h01
`define PHYMR_ADV_PAUSE_RST   1'b1
`define PHYMR_ADV_AB_RST      4'hF
`define PHYMR_LP_RST          4'h0

// Port-2 control fields
`define PHYMR_CTL_LOOPBACK    14
`define PHYMR_CTL_FORCE100    13
`define PHYMR_CTL_AN_EN       12
`define PHYMR_CTL_RESTART     9
`define PHYMR_CTL_DUPLEX      8
`define PHYMR_CTL_LB_RST      1'b0
`define PHYMR_CTL_F100_RST    1'b1
`define PHYMR_CTL_AN_RST      1'b1
`define PHYMR_CTL_DUP_RST     1'b1

// Control mirror positions
`define PHYMR_CR4_LOOPBACK    8
`define PHYMR_CR4_AN_EN       7
`define PHYMR_CR4_FORCE100    6
`define PHYMR_CR4_DUPLEX      5
`define PHYMR_CR4_RESTART     13
`define PHYMR_CR4_PAUSE       4

`endif

// ==== phymr_pkg.sv ====
// Purpose: Types shared by the PHY register view
// Assumes: None
// Notes:   Constants live in phymr_defines.svh
package phymr_pkg;

    typedef logic [15:0] phymr_word_t;
    typedef logic [7:0]  phymr_addr_t;

    typedef enum logic [1:0] {
        RST_IDLE,
        RST_PEND,
        RST_PULSE
    } phymr_rst_e;

endpackage : phymr_pkg

// ==== phymr_restart_ctl.sv ====
// Purpose: Self-clearing negotiation restart sequencer
// Assumes: start is a one-cycle write strobe of a one
// Notes:   Bit reads one for two cycles, pulse in the second
`timescale 1ns/1ps
`default_nettype none

module phymr_restart_ctl
    import phymr_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // Control
    input  wire logic start,
    output logic      restart_bit,
    output logic      restart_pulse
);

    phymr_rst_e state_q;
    phymr_rst_e state_d;

    // [RL17] Restart then self-clear
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            RST_IDLE:
            begin
                if (start)
                    state_d = RST_PEND;
            end
            RST_PEND:
            begin
                state_d = RST_PULSE;
            end
            RST_PULSE:
            begin
                state_d = start ? RST_PEND : RST_IDLE;
            end
            default:
            begin
                state_d = RST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            state_q <= RST_IDLE;
        else
            state_q <= state_d;
    end

    assign restart_bit   = (state_q != RST_IDLE);
    assign restart_pulse = (state_q == RST_PULSE);

endmodule : phymr_restart_ctl

`default_nettype wire

// ==== phymr_phy_model.sv ====
// Purpose: Far-side port PHY status source for the register view
// Assumes: Bench sets the negotiation fields between accesses
// Notes:   Unused mirror bits churn each cycle
`timescale 1ns/1ps
`default_nettype none

module phymr_phy_model
    import phymr_pkg::*;
(
    // Clock
    input  wire logic       ref_clk,
    // Fields to present
    input  wire logic [6:0] fields,
    input  wire logic       fail_in,
    // Toward the view
    output phymr_word_t     port1_status_mirror,
    output logic            port2_an_failed
);
    logic [8:0] junk_q = 9'h155;

    // Bits the view must never use
    always_ff @(posedge ref_clk)
        junk_q <= ~junk_q;

    assign port1_status_mirror = {junk_q, fields};
    assign port2_an_failed     = fail_in;
endmodule : phymr_phy_model

`default_nettype wire

// ==== phymr_register_view_monitor.sv ====
// Purpose: Port checker for the PHY register view
// Assumes: Status timing judged only on a steady mirror
// Notes:   Bound to the register view
`timescale 1ns/1ps
`default_nettype none

module phymr_register_view_monitor
    import phymr_pkg::*;
#(
    parameter phymr_word_t ID_LOW  = 16'h0000,
    parameter phymr_word_t ID_HIGH = 16'h0000
)
(
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    // Host bus
    input wire phymr_addr_t host_addr,
    input wire logic        host_wr,
    input wire logic        host_rd,
    input wire logic [1:0]  host_be,
    input wire phymr_word_t host_wdata,
    input wire phymr_word_t host_rdata,
    input wire logic        host_rvalid,
    // PHY side
    input wire phymr_word_t port1_status_mirror,
    input wire phymr_word_t port1_control_mirror,
    input wire phymr_word_t port1_adv_word,
    input wire logic        port2_an_failed,
    input wire phymr_word_t port2_control_mirror,
    input wire logic        port2_loopback,
    input wire logic        port2_an_enable,
    input wire logic        port2_an_restart,
    input wire logic        port2_speed_forced,
    input wire logic        port2_speed_100,
    input wire logic        port2_duplex_forced,
    input wire logic        port2_duplex_full
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence s_rd(logic [6:0] w);
        host_rd && host_addr[7:1] == w;
    endsequence
    sequence s_restart_wr;
        host_wr && host_addr[7:1] == 7'h2C && host_be[1] && host_wdata[9];
    endsequence
    sequence s_pulse_late;
        !port2_an_restart ##1 port2_an_restart ##1 !port2_an_restart;
    endsequence
    sequence s_bit_clear;
        port2_control_mirror[13] [*2]
        ##1 (!port2_control_mirror[13] || $past(host_wr));
    endsequence

    a_rvalid_pulse: assert property (host_rvalid == $past(host_rd))
        else $error("read valid not one cycle after read");
    a_status_fixed: assert property (s_rd(7'h27) |=>
        host_rdata[15:6] == 10'h1E0 && host_rdata[4:3] == 2'b01
        && host_rdata[1:0] == 2'b00)
        else $error("status fixed bits wrong");
    a_status_link: assert property (host_rd
        && host_addr[7:1] == 7'h27
        && $stable(port1_status_mirror[6:5]) |=>
        host_rdata[5] == $past(port1_status_mirror[6])
        && host_rdata[2] == $past(port1_status_mirror[5]))
        else $error("status done or link wrong");
    a_ident_low: assert property (s_rd(7'h28)
        |=> host_rdata == ID_LOW)
        else $error("low id wrong");
    a_ident_high: assert property (s_rd(7'h29)
        |=> host_rdata == ID_HIGH)
        else $error("high id wrong");
    a_partner_fixed: assert property (s_rd(7'h2B) |=>
        host_rdata[15:11] == 5'h00 && !host_rdata[9]
        && host_rdata[4:0] == 5'h01)
        else $error("partner fixed bits wrong");
    a_adv_write: assert property (host_wr
        && host_addr[7:1] == 7'h2A && host_be == 2'h3 |=> port1_adv_word
        == (($past(host_wdata) & 16'h07E0) | 16'h0001))
        else $error("advertisement write wrong");
    a_adv_mirror: assert property (port1_control_mirror
        == {11'h000, port1_adv_word[10], port1_adv_word[8:5]})
        else $error("port-1 control mirror wrong");
    a_ctl_write: assert property (host_wr
        && host_addr[7:1] == 7'h2C && host_be[1]
        |=> port2_loopback == $past(host_wdata[14])
        && port2_speed_100 == $past(host_wdata[13])
        && port2_an_enable == $past(host_wdata[12])
        && port2_duplex_full == $past(host_wdata[8]))
        else $error("control write wrong");
    a_ctl_levels: assert property (port2_speed_forced
        == !port2_an_enable && port2_duplex_forced
        == (!port2_an_enable || port2_an_failed))
        else $error("forced speed or duplex wrong");
    a_restart_pulse: assert property (s_restart_wr |=> s_pulse_late)
        else $error("restart pulse misplaced");
    a_restart_bit: assert property (s_restart_wr |=> s_bit_clear)
        else $error("restart bit not self-clearing");
endmodule : phymr_register_view_monitor

bind phymr_register_view phymr_register_view_monitor
    #(.ID_LOW(ID_LOW), .ID_HIGH(ID_HIGH)) u_mon (
    .ref_clk, .sys_rst, .host_addr, .host_wr, .host_rd, .host_be,
    .host_wdata, .host_rdata, .host_rvalid, .port1_status_mirror,
    .port1_control_mirror, .port1_adv_word, .port2_an_failed,
    .port2_control_mirror, .port2_loopback, .port2_an_enable,
    .port2_an_restart, .port2_speed_forced, .port2_speed_100,
    .port2_duplex_forced, .port2_duplex_full);

`default_nettype wire

// ==== phymr_register_view_tb.sv ====
// Purpose: Self-checking bench for the PHY register view
// Assumes: Host accesses spaced by idle cycles
// Notes:   Model of all registers compared at every read
`timescale 1ns/1ps
`default_nettype none

module phymr_register_view_tb
    import phymr_pkg::*;
;
    localparam phymr_word_t ID_LO = 16'h3C5A; // Arbitrary
    localparam phymr_word_t ID_HI = 16'h0C33; // Arbitrary
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        host_wr = 1'b0;
    logic        host_rd = 1'b0;
    logic [1:0]  host_be = 2'h0;
    phymr_addr_t host_addr = 8'h00;
    phymr_word_t host_wdata = 16'h0000;
    logic [6:0]  fld = 7'h00;
    logic        fail_in = 1'b0;
    phymr_word_t host_rdata, port1_status_mirror, port1_control_mirror;
    phymr_word_t port1_adv_word, port2_control_mirror;
    logic        host_rvalid, port2_an_failed, port2_loopback;
    logic        port2_an_enable, port2_an_restart, port2_speed_forced;
    logic        port2_speed_100, port2_duplex_forced, port2_duplex_full;
    phymr_word_t adv_m = 16'h05E1;
    phymr_word_t ctl_m = 16'h3100;
    logic [15:0] rnd = 16'h94C9;
    int          err_total = 0;
    int          check_count = 0;
    int          pulses = 0;
    int          pulses_m = 0;
    phymr_addr_t addrs [8] = '{8'h4E, 8'h50, 8'h52, 8'h54, 8'h56, 8'h58,
                               8'h5C, 8'h59};

    phymr_register_view #(.ID_LOW(ID_LO), .ID_HIGH(ID_HI)) dut (
        .ref_clk, .sys_rst, .host_addr, .host_wr, .host_rd, .host_be,
        .host_wdata, .host_rdata, .host_rvalid, .port1_status_mirror,
        .port1_control_mirror, .port1_adv_word, .port2_an_failed,
        .port2_control_mirror, .port2_loopback, .port2_an_enable,
        .port2_an_restart, .port2_speed_forced, .port2_speed_100,
        .port2_duplex_forced, .port2_duplex_full);
    phymr_phy_model phy (.ref_clk, .fields(fld), .fail_in,
        .port1_status_mirror, .port2_an_failed);

    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
        if (port2_an_restart === 1'b1)
            pulses++;

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr

    function automatic phymr_word_t exp_rd(input phymr_addr_t a);
        case (a[7:1])
            7'h27: return {5'h0F, 4'h0, 1'b0, fld[6], 2'b01, fld[5], 2'h0};
            7'h28: return ID_LO;
            7'h29: return ID_HI;
            7'h2A: return adv_m;
            7'h2B: return {5'h00, fld[4], 1'b0, fld[3:0], 5'h01};
            7'h2C: return ctl_m;
            default: return 16'h0000;
        endcase
    endfunction : exp_rd

    task automatic cmp_word(input phymr_word_t g, input phymr_word_t e,
                            input string what);
        check_count++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, g, e);
        end
    endtask : cmp_word

    task automatic cmp_bit(input logic g, input logic e, input string what);
        check_count++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD t=%0t %s got %b exp %b", $time, what, g, e);
        end
    endtask : cmp_bit

    task automatic bus_wr(input phymr_addr_t a, input logic [1:0] be,
                          input phymr_word_t d);
        phymr_word_t wm;
        wm = {{8{be[1]}}, {8{be[0]}}};
        @(posedge ref_clk) #1;
        host_addr = a;
        host_be = be;
        host_wdata = d;
        host_wr = 1'b1;
        @(posedge ref_clk) #1;
        host_wr = 1'b0;
        repeat (3) @(posedge ref_clk);
        if (a[7:1] == 7'h2A)
            adv_m = (adv_m & ~(wm & 16'h07E0)) | (d & wm & 16'h07E0);
        if (a[7:1] == 7'h2C)
            ctl_m = (ctl_m & ~(wm & 16'h7100)) | (d & wm & 16'h7100);
        if (a[7:1] == 7'h2C && be[1] && d[9])
            pulses_m++;
    endtask : bus_wr

    task automatic bus_rd(input phymr_addr_t a);
        @(posedge ref_clk) #1;
        host_addr = a;
        host_rd = 1'b1;
        @(posedge ref_clk) #1;
        host_rd = 1'b0;
        cmp_bit(host_rvalid, 1'b1, "rvalid");
        cmp_word(host_rdata, exp_rd(a), "rdata");
    endtask : bus_rd

    task automatic read_all;
        foreach (addrs[k])
            bus_rd(addrs[k]);
        cmp_word(port1_adv_word, adv_m, "adv");
        cmp_word(port1_control_mirror, {11'h000, adv_m[10], adv_m[8:5]},
                 "p1 mirror");
        cmp_word(port2_control_mirror, {7'h00, ctl_m[14], ctl_m[12],
                 ctl_m[13], ctl_m[8], 5'h00}, "p2 mirror");
        cmp_bit(port2_loopback, ctl_m[14], "loop");
        cmp_bit(port2_speed_100, ctl_m[13], "s100");
        cmp_bit(port2_speed_forced, !ctl_m[12], "sforce");
        cmp_bit(port2_an_enable, ctl_m[12], "an");
        cmp_bit(port2_duplex_full, ctl_m[8], "dfull");
        cmp_bit(port2_duplex_forced, !ctl_m[12] || fail_in, "dfrc");
        cmp_word(16'(pulses), 16'(pulses_m), "restarts");
    endtask : read_all

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        tally_and_finish();
    end

    initial
    begin
        repeat (12) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        read_all();
        foreach (addrs[k])
            bus_wr(addrs[k], 2'h3, 16'hFFFF);
        read_all();
        foreach (addrs[k])
            bus_wr(addrs[k], 2'h3, 16'h0000);
        read_all();
        for (int i = 0; i < 40; i++)
        begin
            rnd = lfsr(rnd);
            fld = rnd[6:0];
            fail_in = rnd[7];
            rnd = lfsr(rnd);
            bus_wr(addrs[rnd[2:0]], rnd[9:8], lfsr(rnd));
            read_all();
        end
        // Mid-run reset brings the writable fields back to defaults
        @(posedge ref_clk) #1;
        sys_rst = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        adv_m = 16'h05E1;
        ctl_m = 16'h3100;
        read_all();
        tally_and_finish();
    end
endmodule : phymr_register_view_tb

`default_nettype wire
